// ---- hdl/fna_accum.sv ----
// module: modulo-5/8 fraction accumulator stepped once per comparison cycle
`timescale 1ns/10ps
module fna_accum
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        step,
	input  wire logic        enable,
	input  wire logic        modulus_select,
	input  wire logic [2:0]  fraction_numerator,
	output logic      [2:0]  fraction_accumulator,
	output logic             overflow
);
	import fna_pkg::*;

	typedef struct packed {
		logic [2:0] acc;
		logic       ovf;
	} fna_acc_st_t;

	fna_acc_st_t st_q;
	fna_acc_st_t st_d;
	logic [3:0]  sum;
	logic [3:0]  fraction_modulus;

	always_comb
	begin
		st_d             = st_q;
		fraction_modulus = modulus_select ? FNA_MOD_EIGHT : {1'b0, FNA_MOD_FIVE};
		sum              = {1'b0, st_q.acc} + {1'b0, fraction_numerator};
		if (step)
		begin
			st_d.ovf = 1'b0;
			if (!enable)
				st_d.acc = FNA_ACC_RESET;
			else if (sum >= fraction_modulus)
			begin
				st_d.acc = 3'(sum - fraction_modulus);
				st_d.ovf = 1'b1;
			end
			else
				st_d.acc = sum[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign fraction_accumulator = st_q.acc;
	assign overflow             = st_q.ovf;
endmodule // fna_accum

// ---- hdl/fna_top.sv ----
// module: fractional-n control with apb registers
`timescale 1ns/10ps
module fna_top
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire fna_pkg::fna_apb_req_t  apb_req,
	output fna_pkg::fna_apb_rsp_t       apb_rsp,
	input  wire logic                   ref_tick,
	input  wire logic                   comp_edge,
	input  wire logic                   prescaler_cycle_end,
	output logic                        modulus_control,
	output logic                 [2:0]  comp_amplitude,
	output logic                        comp_gate,
	output logic                 [8:0]  pump_level_out,
	output logic                 [19:0] total_division
);
	import fna_pkg::*;

	typedef struct packed {
		fna_cfg_t     cfg;
		fna_apb_rsp_t rsp;
		logic         pending;
		logic         mc;
		logic [2:0]   amp;
		logic         gate;
		logic [1:0]   win_cnt;
		logic [8:0]   pump;
		logic [19:0]  total;
		logic [2:0]   ovf_seen;
	} fna_state_t;

	fna_state_t st_q;
	fna_state_t st_d;
	logic [2:0] acc;
	logic       ovf;
	logic       wr;
	logic       rd;
	logic [8:0] code_in;
	logic [19:0] tot_calc;

	fna_accum u_accum
	(
		.pclk                 (pclk),
		.presetn              (presetn),
		.step                 (comp_edge),
		.enable               (st_q.cfg.enable),
		.modulus_select       (st_q.cfg.modulus_select),
		.fraction_numerator   (st_q.cfg.fraction_numerator),
		.fraction_accumulator (acc),
		.overflow             (ovf)
	);

	always_comb
	begin
		st_d     = st_q;
		wr       = apb_req.psel && apb_req.penable && apb_req.pwrite;
		rd       = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
		code_in  = apb_req.pwdata[8:0];
		tot_calc = (20'(st_q.cfg.first_divider_count) + 20'(st_q.cfg.second_divider_count))
			* 20'(st_q.cfg.prescaler_base_ratio) + 20'(st_q.cfg.second_divider_count);

		// ****************************************
		// apb slave: one wait state, then ready
		// ****************************************
		st_d.rsp.pready  = 1'b0;
		st_d.rsp.pslverr = 1'b0;
		if (apb_req.psel && !apb_req.penable)
		begin
			st_d.pending = 1'b1;
			st_d.rsp.prdata = '0;
			if (rd)
			begin
				case (apb_req.paddr)
					FNA_ADDR_CTRL: st_d.rsp.prdata = 32'({st_q.cfg.enable, st_q.cfg.modulus_select,
						1'b0, st_q.cfg.fraction_numerator});
					FNA_ADDR_DIV: st_d.rsp.prdata = {st_q.cfg.prescaler_base_ratio,
						st_q.cfg.second_divider_count, 5'h00, st_q.cfg.first_divider_count};
					FNA_ADDR_PUMP: st_d.rsp.prdata = 32'(st_q.cfg.pump_level_code);
					FNA_ADDR_STAT: st_d.rsp.prdata = 32'({st_q.ovf_seen, st_q.mc, acc});
					FNA_ADDR_TOTAL: st_d.rsp.prdata = 32'(st_q.total);
					default: st_d.rsp.prdata = '0;
				endcase
			end
		end
		else if (st_q.pending && apb_req.psel && apb_req.penable)
		begin
			st_d.pending     = 1'b0;
			st_d.rsp.pready  = 1'b1;
			st_d.rsp.pslverr = !(apb_req.paddr inside {FNA_ADDR_CTRL, FNA_ADDR_DIV, FNA_ADDR_PUMP,
				FNA_ADDR_STAT, FNA_ADDR_TOTAL});
			if (wr)
			begin
				case (apb_req.paddr)
					FNA_ADDR_CTRL:
					begin
						st_d.cfg.enable         = apb_req.pwdata[FNA_CTRL_ENABLE];
						st_d.cfg.modulus_select = apb_req.pwdata[FNA_CTRL_MODSEL];
					end
					FNA_ADDR_DIV:
					begin
						st_d.cfg.first_divider_count  = apb_req.pwdata[FNA_DIV_FIRST_LSB +: 11];
						st_d.cfg.second_divider_count = apb_req.pwdata[FNA_DIV_SECOND_LSB +: 8];
						st_d.cfg.prescaler_base_ratio = apb_req.pwdata[FNA_DIV_RATIO_LSB +: 8];
						st_d.cfg.fraction_numerator   = apb_req.pwdata[13:11];
					end
					FNA_ADDR_PUMP: st_d.cfg.pump_level_code = (code_in > FNA_CODE_MAX) ? FNA_CODE_MAX : code_in;
					default: ;
				endcase
			end
		end
		else if (!apb_req.psel)
			st_d.pending = 1'b0;

		// ****************************************
		// modulus control and compensation
		// ****************************************
		// one lengthened prescaler cycle
		if (ovf && comp_edge && st_q.cfg.enable)
			st_d.mc = 1'b1;
		else if (prescaler_cycle_end)
			st_d.mc = 1'b0;
		if (ovf && comp_edge)
			st_d.ovf_seen = st_q.ovf_seen + 3'h1;
		st_d.amp = st_q.cfg.enable ? acc : 3'h0;
		if (comp_edge)
		begin
			st_d.gate    = st_q.cfg.enable && (acc != 3'h0);
			st_d.win_cnt = 2'(FNA_WIN_CYCLES - 1);
		end
		else if (ref_tick && st_q.gate)
		begin
			if (st_q.win_cnt == 2'h0)
				st_d.gate = 1'b0;
			else
				st_d.win_cnt = st_q.win_cnt - 2'h1;
		end
		st_d.pump  = st_q.cfg.pump_level_code;
		st_d.total = tot_calc + 20'(st_q.mc);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= '0;
			st_q.cfg.prescaler_base_ratio <= FNA_RATIO_RESET;
		end
		else
			st_q <= st_d;
	end

	assign apb_rsp         = st_q.rsp;
	assign modulus_control = st_q.mc;
	assign comp_amplitude  = st_q.amp;
	assign comp_gate       = st_q.gate;
	assign pump_level_out  = st_q.pump;
	assign total_division  = st_q.total;
endmodule // fna_top

// ---- shared/fna_pkg.sv ----
// package: constants and carriers for the fractional-n accumulator
package fna_pkg;
	// ****************************************
	// widths and values
	// ****************************************
	localparam int unsigned FNA_ACC_W       = 3;
	localparam int unsigned FNA_CNT_W       = 11;
	localparam int unsigned FNA_CODE_W      = 9;
	localparam logic [2:0]  FNA_MOD_FIVE    = 3'h5;
	localparam logic [3:0]  FNA_MOD_EIGHT   = 4'h8;
	localparam logic [8:0]  FNA_CODE_MAX    = 9'h100;
	localparam logic [2:0]  FNA_ACC_RESET   = 3'h0;
	localparam int unsigned FNA_WIN_CYCLES  = 2;

	// ****************************************
	// apb register map
	// ****************************************
	localparam logic [7:0]  FNA_ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  FNA_ADDR_DIV    = 8'h04;
	localparam logic [7:0]  FNA_ADDR_PUMP   = 8'h08;
	localparam logic [7:0]  FNA_ADDR_STAT   = 8'h0c;
	localparam logic [7:0]  FNA_ADDR_TOTAL  = 8'h10;
	// ctrl fields
	localparam int unsigned FNA_CTRL_NUM_LSB = 0;
	localparam int unsigned FNA_CTRL_MODSEL  = 4;
	localparam int unsigned FNA_CTRL_ENABLE  = 5;
	// div fields
	localparam int unsigned FNA_DIV_FIRST_LSB  = 0;
	localparam int unsigned FNA_DIV_SECOND_LSB = 16;
	localparam int unsigned FNA_DIV_RATIO_LSB  = 24;
	localparam logic [7:0]  FNA_RATIO_RESET    = 8'h40;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} fna_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} fna_apb_rsp_t;

	typedef struct packed {
		logic        modulus_select;
		logic        enable;
		logic [2:0]  fraction_numerator;
		logic [10:0] first_divider_count;
		logic [7:0]  second_divider_count;
		logic [7:0]  prescaler_base_ratio;
		logic [8:0]  pump_level_code;
	} fna_cfg_t;
endpackage

// ---- testbench/fna_monitor.sv ----
// checker: apb and modulus-control properties
`timescale 1ns/10ps
module fna_monitor
(
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire fna_pkg::fna_apb_req_t apb_req,
	input wire fna_pkg::fna_apb_rsp_t apb_rsp,
	input wire logic                  comp_edge,
	input wire logic                  prescaler_cycle_end,
	input wire logic                  modulus_control,
	input wire logic [2:0]            comp_amplitude,
	input wire logic                  comp_gate,
	input wire logic [8:0]            pump_level_out
);
	import fna_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****
	// properties
	// ****
	ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	ready_wait_a: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
		else $error("pready not one cycle after access");
	err_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr without pready");
	pump_max_a: assert property (pump_level_out <= 9'h100)
		else $error("pump level above limit");
	mc_cause_a: assert property ($rose(modulus_control) |-> $past(comp_edge))
		else $error("modulus control rose without comparison edge");
	mc_clear_a: assert property (modulus_control && prescaler_cycle_end && !comp_edge |=> !modulus_control)
		else $error("modulus control held past prescaler cycle");
	mc_hold_a: assert property (modulus_control && !prescaler_cycle_end && !apb_req.psel |=> modulus_control)
		else $error("modulus control dropped early");
	amp_step_a: assert property ($changed(comp_amplitude) |-> $past(comp_edge, 2) || $past(apb_req.psel))
		else $error("amplitude changed without comparison edge");
	gate_end_a: assert property ($rose(comp_gate) |-> ##[1:12] !comp_gate)
		else $error("compensation window too long");
	cover property ($rose(modulus_control));
	cover property (apb_rsp.pslverr);
	cover property ($rose(comp_gate));
endmodule // fna_monitor

bind fna_top fna_monitor u_mon(.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.comp_edge(comp_edge), .prescaler_cycle_end(prescaler_cycle_end), .modulus_control(modulus_control),
	.comp_amplitude(comp_amplitude), .comp_gate(comp_gate), .pump_level_out(pump_level_out));

// ---- testbench/fna_prescaler_model.sv ----
// model: dual-modulus prescaler driven by modulus control
`timescale 1ns/10ps
module fna_prescaler_model
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic modulus_control,
	output logic      cycle_end,
	output int        long_count
);
	logic [2:0] cnt_q;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 3'h0;
			cycle_end <= 1'b0;
			long_count <= 0;
		end
		else
		begin
			cycle_end <= (cnt_q == {2'h1, modulus_control});
			cnt_q <= cycle_end ? 3'h0 : cnt_q + 3'h1;
			if (cycle_end && modulus_control)
				long_count <= long_count + 1;
		end
	end
endmodule // fna_prescaler_model

// ---- testbench/fractional_n_accumulator_tb.sv ----
// testbench: apb sequences and fraction pattern checks
`timescale 1ns/10ps
module fractional_n_accumulator_tb;
	import fna_pkg::*;
	logic         pclk = 0, presetn = 0, ref_tick = 0, comp_edge = 0, mon_on = 0, mc_prev = 0, err;
	fna_apb_req_t apb_req = '0;
	fna_apb_rsp_t apb_rsp;
	logic         modulus_control, comp_gate, pce;
	logic [2:0]   comp_amplitude;
	logic [8:0]   pump_level_out;
	logic [19:0]  total_division;
	logic [3:0]   tick = 0;
	logic [31:0]  rd;
	int           failures = 0, check_count = 0, ovf, amp_sum, longs, l0, i;
	int           tab[4][4] = '{'{8'h30, 3, 3, 28}, '{8'h20, 3, 3, 10}, '{8'h30, 1, 1, 28}, '{8'h20, 4, 4, 10}};
	always #2 pclk = ~pclk;
	fna_top u_dut(.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .ref_tick(ref_tick),
		.comp_edge(comp_edge), .prescaler_cycle_end(pce), .modulus_control(modulus_control),
		.comp_amplitude(comp_amplitude), .comp_gate(comp_gate), .pump_level_out(pump_level_out),
		.total_division(total_division));
	fna_prescaler_model u_pre(.pclk(pclk), .presetn(presetn), .modulus_control(modulus_control),
		.cycle_end(pce), .long_count(longs));
	always @(posedge pclk)
	begin
		tick <= tick + 4'h1;
		comp_edge <= (tick == 4'hf);
		ref_tick <= (tick[1:0] == 2'h3);
		mc_prev <= modulus_control;
		if (mon_on && tick == 4'h8)
			amp_sum <= amp_sum + comp_amplitude;
		if (mon_on && modulus_control && !mc_prev)
			ovf <= ovf + 1;
	end
	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdc(string name, logic [7:0] a, logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#40000;
		failures++;
		print_verdict();
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc("div", FNA_ADDR_DIV, 32'h4000_0000);
		rdc("total", FNA_ADDR_TOTAL, 32'h0);
		rdc("unmapped", 8'h14, 32'h0);
		check("slverr", 32'h1, {31'h0, err});
		$display("test reset done");
		wr(FNA_ADDR_DIV, 32'h4001_1cc9);
		rdc("total", FNA_ADDR_TOTAL, 32'h13281);
		check("total port", 32'h13281, {12'h0, total_division});
		rdc("ctrl", FNA_ADDR_CTRL, 32'h3);
		wr(FNA_ADDR_PUMP, 32'h1ff);
		rdc("pump", FNA_ADDR_PUMP, 32'h100);
		wr(FNA_ADDR_PUMP, 32'hc8);
		@(posedge pclk);
		check("pump port", 32'hc8, {23'h0, pump_level_out});
		$display("test registers done");
		for (i = 0; i < 4; i++)
		begin
			wr(FNA_ADDR_CTRL, 32'h0);
			wr(FNA_ADDR_DIV, 32'h4001_04c9 | (tab[i][1] << 11));
			wr(FNA_ADDR_CTRL, tab[i][0]);
			repeat (48) @(posedge pclk);
			while (tick != 4'h8) @(posedge pclk);
			ovf = 0;
			amp_sum = 0;
			l0 = longs;
			mon_on <= 1'b1;
			repeat ((tab[i][0] == 8'h30) ? 128 : 80) @(posedge pclk);
			mon_on <= 1'b0;
			@(posedge pclk);
			check("overflows", tab[i][2], ovf);
			check("amplitude sum", tab[i][3], amp_sum);
			check("long cycles", tab[i][2], longs - l0);
		end
		wr(FNA_ADDR_CTRL, 32'h0);
		repeat (2) @(posedge pclk);
		check("amplitude off", 32'h0, {29'h0, comp_amplitude});
		$display("test fraction done");
		print_verdict();
	end
endmodule // fractional_n_accumulator_tb
